// file: pkg/trpd_defs.vh
// Register map, field positions, reset values and timing constants of the direction detector
`ifndef TRPD_DEFS_VH
`define TRPD_DEFS_VH

// Register byte offsets
`define TRPD_CTRL_OFF 6'h00
`define TRPD_VSIGN_TH_OFF 6'h04
`define TRPD_ISIGN_TH_OFF 6'h08
`define TRPD_FWD_Q_TH_OFF 6'h0C
`define TRPD_REV_Q_TH_OFF 6'h10
`define TRPD_INTQ_TH_OFF 6'h14
`define TRPD_SMOOTH_OFF 6'h18
`define TRPD_CYCLES_OFF 6'h1C
`define TRPD_START_TH_OFF 6'h20
`define TRPD_STATUS_OFF 6'h24
`define TRPD_MASK_OFF 6'h28
`define TRPD_STATE_OFF 6'h2C

// Control register fields
`define TRPD_CTRL_ADV 0
`define TRPD_CTRL_SEL_PERM 1
`define TRPD_CTRL_SEL_INTER 2
`define TRPD_CTRL_SEL_FWD 3
`define TRPD_CTRL_SEL_REV 4
`define TRPD_CTRL_W 5

// Status and mask fields
`define TRPD_EV_FWD 0
`define TRPD_EV_REV 1
`define TRPD_EV_ALARM 2
`define TRPD_EV_START 3
`define TRPD_EV_W 4

// Reset values (Q14 for reactive quantities: 16'h4000 is 1.0)
`define TRPD_CTRL_RST 5'h18
`define TRPD_VSIGN_TH_RST 16'h1F40
`define TRPD_ISIGN_TH_RST 16'h1388
`define TRPD_FWD_Q_TH_RST 16'h0666
`define TRPD_REV_Q_TH_RST 16'h028F
`define TRPD_INTQ_TH_RST 16'h0333
`define TRPD_SMOOTH_RST 16'h0148
`define TRPD_CYCLES_RST 8'h06
`define TRPD_START_TH_RST 16'h07D0

// Fixed point
`define TRPD_QONE 18'h04000
`define TRPD_FRAC 14
`define TRPD_SPC 48

`endif

// file: hw/trpd_top.v
// Transient reactive power earth fault direction detector with AHB-Lite registers
//
// Behaviour
// - Voltage band-pass 220 Hz, then 90 degree lead
// - Current band-pass 220 Hz, no phase shift
// - Voltage sign filter: +1, -1 or 0
// - Current sign filter: +1, -1 or 0
// - Product of signs, range -1 to +1
// - Positive healthy, negative faulty forward line
// - Compare against forward and reverse thresholds
// - Standard and advanced mode select
// - Advanced mode smooths reactive power by factor
// - Advanced mode integrates over cycles after start
// - Forward fault and reverse fault outputs
// - Filters have unity gain at 220 Hz
// - Block input inhibits function, clears fault, alarm and start outputs
// - Clear request clears latched alarms
// - Main alarm output for tripping
// - Start when residual voltage exceeds threshold
// - Alarm from selectable fault signal mix
`include "trpd_defs.vh"

module trpd_top #(
	parameter DW = 16,
	parameter signed [17:0] BP_B0 = 18'sd799,
	parameter signed [17:0] BP_A1 = -18'sd26108,
	parameter signed [17:0] BP_A2 = 18'sd14787,
	parameter signed [17:0] COS_W = 18'sd13742,
	parameter signed [17:0] INV_SIN_W = 18'sd30083,
	parameter [7:0] SPC = `TRPD_SPC
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire sample_strobe,
	input wire [DW-1:0] residual_voltage,
	input wire [DW-1:0] residual_current,
	input wire block_input,
	input wire alarm_clear_request,
	input wire permanent_fault_flag,
	input wire intermittent_fault_flag,
	output reg forward_fault_flag,
	output reg reverse_fault_flag,
	output reg earth_fault_alarm,
	output reg residual_overvoltage_start,
	output reg irq
);

	// Filter word: sample width plus headroom for the resonator peak
	localparam IW = 24;

	// Settings
	reg [`TRPD_CTRL_W-1:0] ctrl;
	reg [15:0] vsign_th;
	reg [15:0] isign_th;
	reg [15:0] forward_q_threshold;
	reg [15:0] reverse_q_threshold;
	reg [15:0] integrated_q_threshold;
	reg [15:0] q_smoothing_factor;
	reg [7:0] cycles;
	reg [15:0] residual_start_threshold;
	reg [`TRPD_EV_W-1:0] status;
	reg [`TRPD_EV_W-1:0] mask;
	wire direction_mode_select = ctrl[`TRPD_CTRL_ADV];

	// Bus data-phase state
	reg wr_pend;
	reg [5:0] wr_addr;
	wire addr_ok = hsel & htrans[1] & hready;
	wire [5:0] a_off = {haddr[5:2], 2'b00};
	wire rd_take = addr_ok & ~hwrite;
	wire wr_take = addr_ok & hwrite;

	// Filter state per path: index 0 voltage, 1 current
	reg signed [IW-1:0] fx1 [0:1];
	reg signed [IW-1:0] fx2 [0:1];
	reg signed [IW-1:0] fy1 [0:1];
	reg signed [IW-1:0] fy2 [0:1];
	wire signed [IW-1:0] fx [0:1];
	wire signed [IW-1:0] fy_next [0:1];
	assign fx[0] = {{(IW-DW){residual_voltage[DW-1]}}, residual_voltage};
	assign fx[1] = {{(IW-DW){residual_current[DW-1]}}, residual_current};

	// Resonator band-pass; B0 = (1 - A2)/2 gives unity gain at centre
	// Coefficients assume a 2400 Hz sample rate; another rate needs new parameters
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_bpf
			wire signed [47:0] acc;
			assign acc = BP_B0 * (fx[g] - fx2[g]) - BP_A1 * fy1[g] - BP_A2 * fy2[g];
			assign fy_next[g] = acc[`TRPD_FRAC+IW-1:`TRPD_FRAC];
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					fx1[g] <= 24'h000000;
					fx2[g] <= 24'h000000;
					fy1[g] <= 24'h000000;
					fy2[g] <= 24'h000000;
				end else if (block_input) begin
					fx1[g] <= 24'h000000;
					fx2[g] <= 24'h000000;
					fy1[g] <= 24'h000000;
					fy2[g] <= 24'h000000;
				end else if (sample_strobe) begin
					fx1[g] <= fx[g];
					fx2[g] <= fx1[g];
					fy1[g] <= fy_next[g];
					fy2[g] <= fy1[g];
				end
			end
		end
	endgenerate

	// Quarter-cycle lead on narrowband voltage: (y*cos w - y_prev)/sin w
	wire signed [47:0] lead_a = fy1[0] * COS_W;
	wire signed [IW-1:0] lead_d = lead_a[`TRPD_FRAC+IW-1:`TRPD_FRAC] - fy2[0];
	wire signed [47:0] lead_b = lead_d * INV_SIN_W;
	wire signed [IW-1:0] shifted_voltage_component = lead_b[`TRPD_FRAC+IW-1:`TRPD_FRAC];
	wire signed [IW-1:0] filtered_current_component = fy1[1];

	// Three-level sign filters
	// Thresholds are unsigned settings widened into the filter word
	wire signed [IW-1:0] vth = {8'h00, vsign_th};
	wire signed [IW-1:0] ith = {8'h00, isign_th};
	wire v_pos = shifted_voltage_component > vth;
	wire v_neg = shifted_voltage_component < -vth;
	wire i_pos = filtered_current_component > ith;
	wire i_neg = filtered_current_component < -ith;

	// Sign product expressed in Q14, so +1 is exactly one unit
	wire q_plus = (v_pos & i_pos) | (v_neg & i_neg);
	wire q_minus = (v_pos & i_neg) | (v_neg & i_pos);
	wire signed [17:0] q_tran = q_plus ? `TRPD_QONE : (q_minus ? -`TRPD_QONE : 18'h00000);

	// Smoothing step; factor is Q14, so a small factor slows response
	// Truncating the step rounds toward minus infinity, so Qn may rest up to 16384/factor LSB low
	reg signed [17:0] smoothed_reactive_power;
	wire signed [18:0] q_diff = {q_tran[17], q_tran} - {smoothed_reactive_power[17],
		smoothed_reactive_power};
	wire signed [36:0] q_step = q_diff * $signed({1'b0, q_smoothing_factor});
	wire signed [17:0] q_smooth_next = smoothed_reactive_power
		+ q_step[`TRPD_FRAC+17:`TRPD_FRAC];
	wire signed [17:0] qn_next = direction_mode_select ? q_smooth_next : q_tran;

	// Start detection on the instantaneous residual voltage magnitude
	// Limitation: start dips near every zero crossing; the window logic rides through
	wire [DW-1:0] v_mag = residual_voltage[DW-1] ? (~residual_voltage + 1'b1) : residual_voltage;
	wire start_now = v_mag > residual_start_threshold;

	// Integration window length in samples
	reg signed [31:0] integrated_reactive_power;
	reg [15:0] win_cnt;
	reg win_run;
	wire [15:0] win_len = cycles * SPC;
	wire win_done = win_cnt >= win_len;
	wire signed [31:0] intq_lim = $signed({16'h0000, integrated_q_threshold}) * $signed({24'h0, SPC});

	// Direction decisions; negative reactive power means the forward line is faulty
	// The integral is consulted only once its window has run out
	wire fwd_inst = smoothed_reactive_power <= -$signed({2'b00, forward_q_threshold});
	wire rev_inst = smoothed_reactive_power >= $signed({2'b00, reverse_q_threshold});
	wire undecided = ~fwd_inst & ~rev_inst;
	wire use_int = direction_mode_select & undecided & win_done;
	wire fwd_int = use_int & (integrated_reactive_power <= -intq_lim);
	wire rev_int = use_int & (integrated_reactive_power >= intq_lim);
	wire fwd_hit = residual_overvoltage_start & (fwd_inst | fwd_int);
	wire rev_hit = residual_overvoltage_start & (rev_inst | rev_int);

	// Alarm source selection
	// Sources are levels; a source that drops leaves the latched alarm set
	wire alarm_src = (ctrl[`TRPD_CTRL_SEL_PERM] & permanent_fault_flag)
		| (ctrl[`TRPD_CTRL_SEL_INTER] & intermittent_fault_flag)
		| (ctrl[`TRPD_CTRL_SEL_FWD] & forward_fault_flag)
		| (ctrl[`TRPD_CTRL_SEL_REV] & reverse_fault_flag);

	// Window arms at the first start of a fault and keeps running through the short
	// start dips at zero crossings, which would otherwise restart it every half cycle;
	// block or a clear request rearms it for the next fault
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			win_run <= 1'b0;
		else if (block_input || alarm_clear_request)
			win_run <= 1'b0;
		else if (sample_strobe && residual_overvoltage_start)
			win_run <= 1'b1;
	end

	// Reactive power pipeline, start and integration, updated on a sample, cleared under block
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smoothed_reactive_power <= 18'h00000;
			residual_overvoltage_start <= 1'b0;
			integrated_reactive_power <= 32'h00000000;
			win_cnt <= 16'h0000;
		end else if (block_input) begin
			smoothed_reactive_power <= 18'h00000;
			residual_overvoltage_start <= 1'b0;
			integrated_reactive_power <= 32'h00000000;
			win_cnt <= 16'h0000;
		end else if (sample_strobe) begin
			smoothed_reactive_power <= qn_next;
			residual_overvoltage_start <= start_now;
			if (!win_run) begin
				// Integral stays empty until the window is armed
				integrated_reactive_power <= 32'h00000000;
				win_cnt <= 16'h0000;
			end else if (!win_done) begin
				integrated_reactive_power <= integrated_reactive_power
					+ {{14{smoothed_reactive_power[17]}}, smoothed_reactive_power};
				win_cnt <= win_cnt + 16'h0001;
			end
		end
	end

	// Latched fault outputs and main alarm; clear request drops the latches
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			forward_fault_flag <= 1'b0;
			reverse_fault_flag <= 1'b0;
			earth_fault_alarm <= 1'b0;
		end else if (block_input) begin
			forward_fault_flag <= 1'b0;
			reverse_fault_flag <= 1'b0;
			earth_fault_alarm <= 1'b0;
		end else if (alarm_clear_request) begin
			forward_fault_flag <= 1'b0;
			reverse_fault_flag <= 1'b0;
			earth_fault_alarm <= 1'b0;
		end else begin
			if (sample_strobe && fwd_hit)
				forward_fault_flag <= 1'b1;
			if (sample_strobe && rev_hit)
				reverse_fault_flag <= 1'b1;
			if (alarm_src)
				earth_fault_alarm <= 1'b1;
		end
	end

	// Event edges for the sticky status register
	// Edge registers reset low, matching the idle level of each source
	reg fwd_q;
	reg rev_q;
	reg alm_q;
	reg st_q;
	wire [`TRPD_EV_W-1:0] events = {residual_overvoltage_start & ~st_q,
		earth_fault_alarm & ~alm_q, reverse_fault_flag & ~rev_q, forward_fault_flag & ~fwd_q};
	wire status_rd = rd_take && (a_off == `TRPD_STATUS_OFF);
	// New events win over the read clear so none is lost
	wire [`TRPD_EV_W-1:0] next_status = (status & {`TRPD_EV_W{~status_rd}}) | events;

	// Edge registers, sticky status and interrupt; irq rises with its status bit
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fwd_q <= 1'b0;
			rev_q <= 1'b0;
			alm_q <= 1'b0;
			st_q <= 1'b0;
			status <= 4'h0;
			irq <= 1'b0;
		end else begin
			fwd_q <= forward_fault_flag;
			rev_q <= reverse_fault_flag;
			alm_q <= earth_fault_alarm;
			st_q <= residual_overvoltage_start;
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// Read mux, sampled in the address phase so hrdata comes from a flop
	reg [31:0] rd_mux;
	always @* begin
		case (a_off)
			`TRPD_CTRL_OFF: rd_mux = {27'h0, ctrl};
			`TRPD_VSIGN_TH_OFF: rd_mux = {16'h0, vsign_th};
			`TRPD_ISIGN_TH_OFF: rd_mux = {16'h0, isign_th};
			`TRPD_FWD_Q_TH_OFF: rd_mux = {16'h0, forward_q_threshold};
			`TRPD_REV_Q_TH_OFF: rd_mux = {16'h0, reverse_q_threshold};
			`TRPD_INTQ_TH_OFF: rd_mux = {16'h0, integrated_q_threshold};
			`TRPD_SMOOTH_OFF: rd_mux = {16'h0, q_smoothing_factor};
			`TRPD_CYCLES_OFF: rd_mux = {24'h0, cycles};
			`TRPD_START_TH_OFF: rd_mux = {16'h0, residual_start_threshold};
			`TRPD_STATUS_OFF: rd_mux = {28'h0, status};
			`TRPD_MASK_OFF: rd_mux = {28'h0, mask};
			`TRPD_STATE_OFF: rd_mux = {win_done, earth_fault_alarm, reverse_fault_flag,
				forward_fault_flag, residual_overvoltage_start, 9'h000, smoothed_reactive_power};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// A read straight after a write to the same word must see the new value,
	// because the write only lands at the end of its data phase
	// Forwarding covers only writable words; status and state read live
	reg [31:0] wr_fwd_mask;
	always @* begin
		case (wr_addr)
			`TRPD_CTRL_OFF: wr_fwd_mask = 32'h0000001F;
			`TRPD_VSIGN_TH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_ISIGN_TH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_FWD_Q_TH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_REV_Q_TH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_INTQ_TH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_SMOOTH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_CYCLES_OFF: wr_fwd_mask = 32'h000000FF;
			`TRPD_START_TH_OFF: wr_fwd_mask = 32'h0000FFFF;
			`TRPD_MASK_OFF: wr_fwd_mask = 32'h0000000F;
			default: wr_fwd_mask = 32'h00000000;
		endcase
	end
	wire wr_hit = wr_pend && (wr_addr == a_off) && (wr_fwd_mask != 32'h00000000);
	wire [31:0] rd_word = wr_hit ? (hwdata & wr_fwd_mask) : rd_mux;

	// AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
	// hsize is ignored: only whole-word transfers are decoded
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend <= 1'b0;
			wr_addr <= 6'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= wr_take;
			if (wr_take)
				wr_addr <= a_off;
			if (rd_take)
				hrdata <= rd_word;
		end
	end

	// Register writes land in the data phase
	// Unmapped offsets fall to the default branch and change nothing
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `TRPD_CTRL_RST;
			vsign_th <= `TRPD_VSIGN_TH_RST;
			isign_th <= `TRPD_ISIGN_TH_RST;
			forward_q_threshold <= `TRPD_FWD_Q_TH_RST;
			reverse_q_threshold <= `TRPD_REV_Q_TH_RST;
			integrated_q_threshold <= `TRPD_INTQ_TH_RST;
			q_smoothing_factor <= `TRPD_SMOOTH_RST;
			cycles <= `TRPD_CYCLES_RST;
			residual_start_threshold <= `TRPD_START_TH_RST;
			mask <= 4'h0;
		end else if (wr_pend) begin
			case (wr_addr)
				`TRPD_CTRL_OFF: ctrl <= hwdata[`TRPD_CTRL_W-1:0];
				`TRPD_VSIGN_TH_OFF: vsign_th <= hwdata[15:0];
				`TRPD_ISIGN_TH_OFF: isign_th <= hwdata[15:0];
				`TRPD_FWD_Q_TH_OFF: forward_q_threshold <= hwdata[15:0];
				`TRPD_REV_Q_TH_OFF: reverse_q_threshold <= hwdata[15:0];
				`TRPD_INTQ_TH_OFF: integrated_q_threshold <= hwdata[15:0];
				`TRPD_SMOOTH_OFF: q_smoothing_factor <= hwdata[15:0];
				`TRPD_CYCLES_OFF: cycles <= hwdata[7:0];
				`TRPD_START_TH_OFF: residual_start_threshold <= hwdata[15:0];
				`TRPD_MASK_OFF: mask <= hwdata[`TRPD_EV_W-1:0];
				default: ctrl <= ctrl;
			endcase
		end
	end

endmodule

// file: verification/trpd_checker.sv
// Port assertions for the direction detector
module trpd_checker (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire sample_strobe,
	input wire block_input,
	input wire alarm_clear_request,
	input wire forward_fault_flag,
	input wire reverse_fault_flag,
	input wire earth_fault_alarm,
	input wire residual_overvoltage_start
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Zero-wait slave that never errors
	property p_ready; hreadyout && !hresp; endproperty
	a_ready: assert property (p_ready) else $error("bus slave stalled or errored");
	// Two cycles of block leave the fault, alarm and start outputs low
	property p_block; block_input ##1 block_input |-> !forward_fault_flag &&
		!reverse_fault_flag && !earth_fault_alarm && !residual_overvoltage_start; endproperty
	a_block: assert property (p_block) else $error("outputs alive under block");
	// Clear wins over a new set in the same cycle
	property p_clear; alarm_clear_request |=> !forward_fault_flag && !reverse_fault_flag &&
		!earth_fault_alarm; endproperty
	a_clear: assert property (p_clear) else $error("latched alarms survive clear");
	// Direction is decided only on a sample
	property p_fwd_rise; $rose(forward_fault_flag) |-> $past(sample_strobe); endproperty
	a_fwd_rise: assert property (p_fwd_rise) else $error("forward flag off sample");
	property p_rev_rise; $rose(reverse_fault_flag) |-> $past(sample_strobe); endproperty
	a_rev_rise: assert property (p_rev_rise) else $error("reverse flag off sample");
	// Flags stay latched until clear or block
	property p_fwd_hold; $fell(forward_fault_flag) |->
		$past(alarm_clear_request) || $past(block_input); endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("forward flag dropped");
	property p_rev_hold; $fell(reverse_fault_flag) |->
		$past(alarm_clear_request) || $past(block_input); endproperty
	a_rev_hold: assert property (p_rev_hold) else $error("reverse flag dropped");
	// Start moves only with a sample or under block
	property p_start; !sample_strobe && !block_input |=> $stable(residual_overvoltage_start);
	endproperty
	a_start: assert property (p_start) else $error("start changed off sample");
	c_fwd: cover property ($rose(forward_fault_flag));
	c_rev: cover property ($rose(reverse_fault_flag));
	c_alarm: cover property ($rose(earth_fault_alarm));
endmodule

bind trpd_top trpd_checker i_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.sample_strobe(sample_strobe),
	.block_input(block_input),
	.alarm_clear_request(alarm_clear_request),
	.forward_fault_flag(forward_fault_flag),
	.reverse_fault_flag(reverse_fault_flag),
	.earth_fault_alarm(earth_fault_alarm),
	.residual_overvoltage_start(residual_overvoltage_start)
);

// file: verification/trpd_front.sv
// Sampling front end model: paired residual voltage and current samples
module trpd_front (
	input wire hclk,
	input wire run,
	input wire rev_dir,
	input wire [15:0] v_amp,
	input wire [15:0] i_amp,
	output reg sample_strobe,
	output reg [15:0] residual_voltage,
	output reg [15:0] residual_current
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	int k = 0;
	real ph;
	initial begin
		sample_strobe = 1'b0;
		residual_voltage = 16'h0000;
		residual_current = 16'h0000;
	end
	// One 220 Hz pair every fourth clock; tuning is per sample index, not per time
	always @(posedge hclk) begin
		k <= (k + 1) % 4;
		ph = 6.2831853 * 220.0 * n / 2400.0;
		if (run && k == 0) begin
			sample_strobe <= 1'b1;
			// Amplitudes sit well above the recommended sign thresholds
			residual_voltage <= 16'($rtoi(v_amp * $sin(ph)));
			residual_current <= 16'($rtoi(i_amp * $sin(ph + (rev_dir ? 1.5708 : -1.5708))));
			n <= n + 1;
		end else begin
			sample_strobe <= 1'b0;
			// Garbage between strobes so a late capture shows up
			residual_voltage <= ~residual_voltage;
			residual_current <= ~residual_current;
		end
	end
endmodule

// file: verification/tb_transient_reactive_power_direction.sv
// Self-checking bench for the direction detector
`include "trpd_defs.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
	$display("FAIL %s expected %h seen %h", nm, e, s); end end
module tb_transient_reactive_power_direction;
	timeunit 1ns;
	timeprecision 1ns;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg block_input = 1'b0;
	reg alarm_clear_request = 1'b0;
	reg perm = 1'b0;
	reg inter = 1'b0;
	reg run = 1'b0;
	reg rev_dir = 1'b0;
	reg [15:0] v_amp = 16'h0;
	reg [15:0] i_amp = 16'h0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, strobe, fwd, rev, alarm, start, irq;
	wire [15:0] v, i;
	int error_cnt = 0;
	int cmp_count = 0;
	int seed = 91385;
	logic [63:0] q[$];
	logic [63:0] nt;
	logic [15:0] rnd;
	logic rd_ph = 1'b0;
	// Per case: control, reverse, permanent, intermittent, then expected fwd, rev, alarm
	logic [10:0] cases [4] = '{11'h605, 11'h232, 11'h645, 11'h12B};
	trpd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_strobe(strobe),
		.residual_voltage(v), .residual_current(i), .block_input(block_input),
		.alarm_clear_request(alarm_clear_request), .permanent_fault_flag(perm),
		.intermittent_fault_flag(inter), .forward_fault_flag(fwd), .reverse_fault_flag(rev),
		.earth_fault_alarm(alarm), .residual_overvoltage_start(start), .irq(irq));
	trpd_front i_front (.hclk(hclk), .run(run), .rev_dir(rev_dir), .v_amp(v_amp),
		.i_amp(i_amp), .sample_strobe(strobe), .residual_voltage(v), .residual_current(i));
	initial begin
		forever #50 hclk = ~hclk;
	end
	task automatic results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait for hready sampled high at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			`CHK("hreadyout", 1'b1, hreadyout)
			results();
		end
	endtask
	// One single word transfer; a read notes {expected, mask} for the monitor
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [63:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {26'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr)
			q.push_back(e);
		wait_rdy();
	endtask
	// Read data is taken at the edge that ends its data phase
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			nt = q.pop_front();
			`CHK("read data", nt[63:32] & nt[31:0], hrdata & nt[31:0])
		end
		rd_ph = hsel && htrans[1] && !hwrite && hreadyout;
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `TRPD_CTRL_OFF, 0, {27'h0, `TRPD_CTRL_RST, 32'hFFFFFFFF});
		bus(0, `TRPD_VSIGN_TH_OFF, 0, {16'h0, `TRPD_VSIGN_TH_RST, 32'hFFFFFFFF});
		bus(0, `TRPD_ISIGN_TH_OFF, 0, {16'h0, `TRPD_ISIGN_TH_RST, 32'hFFFFFFFF});
		bus(0, `TRPD_REV_Q_TH_OFF, 0, {16'h0, `TRPD_REV_Q_TH_RST, 32'hFFFFFFFF});
		bus(0, `TRPD_CYCLES_OFF, 0, {24'h0, `TRPD_CYCLES_RST, 32'hFFFFFFFF});
		bus(0, `TRPD_MASK_OFF, 0, {32'h0, 32'hFFFFFFFF});
		rnd = $random(seed);
		bus(1, `TRPD_INTQ_TH_OFF, {16'h0, rnd}, 64'h0);
		bus(0, `TRPD_INTQ_TH_OFF, 0, {16'h0, rnd, 32'h0000FFFF});
		bus(1, `TRPD_INTQ_TH_OFF, {16'h0, `TRPD_INTQ_TH_RST}, 64'h0);
		// Unmapped word ignores writes and reads as zero
		bus(1, 6'h34, $random(seed), 64'h0);
		bus(0, 6'h34, 0, {32'h0, 32'hFFFFFFFF});
		bus(1, `TRPD_MASK_OFF, 32'h7, 64'h0);
		foreach (cases[c]) begin
			bus(1, `TRPD_CTRL_OFF, {27'h0, cases[c][10:6]}, 64'h0);
			@(posedge hclk);
			{rev_dir, perm, inter} <= cases[c][5:3];
			v_amp <= 16'd20000 + 16'($random(seed) & 4095);
			i_amp <= 16'd15000 + 16'($random(seed) & 2047);
			block_input <= 1'b1;
			run <= 1'b1;
			repeat (3) @(posedge hclk);
			`CHK("blocked outputs", 4'h0, {fwd, rev, alarm, start})
			block_input <= 1'b0;
			repeat (400) @(posedge hclk);
			// Clear away start-up transients, then let direction settle again
			alarm_clear_request <= 1'b1;
			@(posedge hclk);
			alarm_clear_request <= 1'b0;
			repeat (400) @(posedge hclk);
			`CHK("flags", cases[c][2:0], {fwd, rev, alarm})
			bus(0, `TRPD_STATE_OFF, 0, {1'b0, cases[c][0], cases[c][1], cases[c][2], 28'h0,
				32'h70000000});
			`CHK("irq", 1'b1, irq)
			bus(1, `TRPD_MASK_OFF, 32'h0, 64'h0);
			repeat (2) @(posedge hclk);
			`CHK("irq masked", 1'b0, irq)
			bus(1, `TRPD_MASK_OFF, 32'h7, 64'h0);
			bus(0, `TRPD_STATUS_OFF, 0, {32'h8, 32'h8});
		end
		results();
	end
endmodule
